/* inc/dvif_defs.svh */
// Constants of the dual voltage input formatter
//------------------------------------------------------------
// Notes on behaviour
// - Two 16-bit words, one per channel
// - Magnitude occupies bits 14 down to 5
// - Value zero to 32736, steps of 32
// - Count 32000 equals 10 V, V=C/3200
// - Above 32000 reported unchanged, no flag
// - Image lives in registers 45392 to 49487
// - Two channel words take adjacent registers
// - Register location follows island slot position
// - Global interrupt enable set before data delivery
// - No configurable parameters, no reflex actions
// - Both words refreshed every 5.0 ms
//------------------------------------------------------------
`ifndef DVIF_DEFS_SVH
`define DVIF_DEFS_SVH

// Word layout
`define DVIF_WORD_W 16
`define DVIF_MAG_W 10
`define DVIF_MAG_LSB 5
`define DVIF_MAG_MSB 14
`define DVIF_FULL_SCALE 16'h7D00
`define DVIF_WORD_RST 16'h0000

// Island register image
`define DVIF_IMG_FIRST 16'hB150
`define DVIF_IMG_LAST 16'hC14F
`define DVIF_IMG_SIZE 4096

// Timing
`define DVIF_CLK_MHZ 100
`define DVIF_RESP_TIME_US 5000
`define DVIF_REFRESH_CYC (`DVIF_RESP_TIME_US * `DVIF_CLK_MHZ)

// Buffering
`define DVIF_FIFO_DEPTH 4

`endif

/* inc/dvif_link_if.sv */
// Link between the formatter and the island network interface
`timescale 1ns/1ns
`default_nettype none
interface dvif_link_if
	import dvif_pkg::*;
(
	input wire logic sys_clk_i
);
	logic valid;
	logic ready;
	dvif_word_t word;
	dvif_chan_t chan;

	// Formatter end drives words
	modport dev (output valid, output word, output chan, input ready);
	// Network interface end takes them
	modport nim (input valid, input word, input chan, output ready);
endinterface : dvif_link_if
`default_nettype wire

/* inc/dvif_pkg.sv */
// Types shared by both ends of the formatter link
package dvif_pkg;
	// Channel index carried with each word
	typedef enum logic {DVIF_CH_ONE, DVIF_CH_TWO} dvif_chan_t;
	// Formatted channel word
	typedef logic [15:0] dvif_word_t;
endpackage : dvif_pkg

/* rtl/dvif_fifo.sv */
// Shift-register FIFO with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module dvif_fifo
	import dvif_pkg::*;
#(
	parameter int WIDTH = 17,
	parameter int DEPTH = 4
)
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic srst_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	// Elaboration check
	if (DEPTH < 2 || WIDTH < 1)
	begin : g_bad
		$error("dvif_fifo needs DEPTH >= 2 and WIDTH >= 1");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic [CW-1:0] wr_idx;
	logic valid_q;
	logic push;
	logic pop;

	// Handshakes; a full FIFO refuses, which stalls the writer
	assign in_ready_o = (cnt_q != FULL);
	assign push = in_valid_i && in_ready_o;
	assign pop = valid_q && out_ready_i;
	assign wr_idx = pop ? cnt_q - CW'(1) : cnt_q;
	assign cnt_d = cnt_q + CW'(push) - CW'(pop);
	assign out_valid_o = valid_q;
	assign out_data_o = mem_q[0];

	// Fill count and registered non-empty flag
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			cnt_q <= '0;
			valid_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			valid_q <= (cnt_d != '0);
		end
	end

	// Storage: head always at entry 0, so the output is a flop
	for (genvar i = 0; i < DEPTH; i++)
	begin : g_ent
		always_ff @(posedge sys_clk_i)
		begin
			if (srst_i)
				mem_q[i] <= '0;
			else if (push && wr_idx == CW'(i))
				mem_q[i] <= in_data_i;
			else if (pop)
				mem_q[i] <= (i == DEPTH - 1) ? '0 : mem_q[(i + 1) % DEPTH];
		end
	end
endmodule : dvif_fifo
`default_nettype wire

/* rtl/dvif_formatter.sv */
// Formatter end: samples two channels and sends two words
`timescale 1ns/1ns
`default_nettype none
`include "dvif_defs.svh"
module dvif_formatter
	import dvif_pkg::*;
#(
	parameter int REFRESH_CYC = `DVIF_REFRESH_CYC,
	parameter int FIFO_DEPTH = `DVIF_FIFO_DEPTH
)
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic srst_i,
	// Converter on the same clock
	output logic conv_start_o,
	input wire logic conv_done_i,
	input wire logic [`DVIF_MAG_W-1:0] conv_one_i,
	input wire logic [`DVIF_MAG_W-1:0] conv_two_i,
	// Status
	output logic refresh_o,
	output logic overrun_o,
	// Link to the network interface
	dvif_link_if.dev link
);
	localparam int TW = $clog2(REFRESH_CYC);
	localparam logic [TW-1:0] TLAST = TW'(REFRESH_CYC - 1);

	// Elaboration check
	if (REFRESH_CYC < 8 || FIFO_DEPTH < 2)
	begin : g_bad
		$error("dvif_formatter needs REFRESH_CYC >= 8 and FIFO_DEPTH >= 2");
	end

	typedef enum logic [1:0] {S_IDLE, S_CONV, S_PUSH_ONE, S_PUSH_TWO} dvif_state_t;

	//------------------------------------------------------------
	// Word formatting
	//------------------------------------------------------------

	// Left-align the magnitude; top bit and low five bits stay zero.
	// Full scale 32000 is not special, so no over-range mark exists.
	function automatic dvif_word_t fmt_word(input logic [`DVIF_MAG_W-1:0] mag);
		dvif_word_t w;
		w = `DVIF_WORD_RST;
		w[`DVIF_MAG_MSB:`DVIF_MAG_LSB] = mag;
		return w;
	endfunction : fmt_word

	//------------------------------------------------------------
	// Refresh timer
	//------------------------------------------------------------

	logic [TW-1:0] tmr_q;
	logic tick_q;
	logic pend_q;
	dvif_state_t state_q;
	logic [`DVIF_MAG_W-1:0] mag_one_q;
	logic [`DVIF_MAG_W-1:0] mag_two_q;
	logic conv_start_q;
	logic refresh_q;
	logic overrun_q;
	logic f_in_valid;
	logic f_in_ready;
	logic [`DVIF_WORD_W:0] f_in_data;
	logic [`DVIF_WORD_W:0] f_out_data;

	// Fixed period; nothing software sets can change it
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			tmr_q <= '0;
			tick_q <= 1'b0;
		end
		else
		begin
			tick_q <= (tmr_q == TLAST);
			tmr_q <= (tmr_q == TLAST) ? '0 : tmr_q + TW'(1);
		end
	end

	// The first tick during a busy cycle waits instead of being lost.
	// Leaving idle consumes one request; if a tick and a pending
	// request meet there, the tick is kept so neither is dropped.
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			pend_q <= 1'b0;
		else if (tick_q && state_q != S_IDLE)
			pend_q <= 1'b1;
		else if (state_q == S_IDLE)
			pend_q <= pend_q && tick_q;
	end

	// Overrun: a second tick arrived while one was still pending.
	// The flagged tick is lost; the frame after it still runs.
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			overrun_q <= 1'b0;
		else
			overrun_q <= tick_q && pend_q && state_q != S_IDLE;
	end

	//------------------------------------------------------------
	// Sequencer
	//------------------------------------------------------------

	// Start a conversion, then queue sensor one before sensor two
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			state_q <= S_IDLE;
		else
		begin
			case (state_q)
				S_IDLE:
					if (tick_q || pend_q)
						state_q <= S_CONV;
				S_CONV:
					if (conv_done_i)
						state_q <= S_PUSH_ONE;
				S_PUSH_ONE:
					if (f_in_ready)
						state_q <= S_PUSH_TWO;
				S_PUSH_TWO:
					if (f_in_ready)
						state_q <= S_IDLE;
				default:
					state_q <= S_IDLE;
			endcase
		end
	end

	// One-cycle start strobe on entry to conversion
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			conv_start_q <= 1'b0;
		else
			conv_start_q <= (state_q == S_IDLE) && (tick_q || pend_q);
	end

	// Both channels are caught together from one conversion
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			mag_one_q <= '0;
			mag_two_q <= '0;
		end
		else if (state_q == S_CONV && conv_done_i)
		begin
			mag_one_q <= conv_one_i;
			mag_two_q <= conv_two_i;
		end
	end

	// Pulse once both words of a frame are queued
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			refresh_q <= 1'b0;
		else
			refresh_q <= (state_q == S_PUSH_TWO) && f_in_ready;
	end

	//------------------------------------------------------------
	// Buffer and link
	//------------------------------------------------------------

	// Channel index rides in the top bit beside the word
	assign f_in_valid = (state_q == S_PUSH_ONE) || (state_q == S_PUSH_TWO);
	always_comb
	begin
		if (state_q == S_PUSH_TWO)
			f_in_data = {1'b1, fmt_word(mag_two_q)};
		else
			f_in_data = {1'b0, fmt_word(mag_one_q)};
	end

	// A stalled network side backs up here and holds the sequencer
	dvif_fifo #(
		.WIDTH(`DVIF_WORD_W + 1),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.in_valid_i(f_in_valid),
		.in_ready_o(f_in_ready),
		.in_data_i(f_in_data),
		.out_valid_o(link.valid),
		.out_ready_i(link.ready),
		.out_data_o(f_out_data)
	);

	//------------------------------------------------------------
	// Outputs
	//------------------------------------------------------------

	// Link fields and status pins come straight from flops
	assign link.word = f_out_data[`DVIF_WORD_W-1:0];
	assign link.chan = dvif_chan_t'(f_out_data[`DVIF_WORD_W]);
	assign conv_start_o = conv_start_q;
	assign refresh_o = refresh_q;
	assign overrun_o = overrun_q;
endmodule : dvif_formatter
`default_nettype wire

/* rtl/dvif_island_nim.sv */
// Network interface end: collects the word pair into registers
`timescale 1ns/1ns
`default_nettype none
`include "dvif_defs.svh"
module dvif_island_nim
	import dvif_pkg::*;
#(
	parameter int SLOT_W = 8
)
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic srst_i,
	// Configuration
	input wire logic irq_enable_i,
	input wire logic [SLOT_W-1:0] slot_i,
	// Register image
	output logic [15:0] ch_one_word_o,
	output logic [15:0] ch_two_word_o,
	output logic [15:0] first_reg_num_o,
	output logic image_update_o,
	output logic image_valid_o,
	// Link to the formatter
	dvif_link_if.nim link
);
	// Two words per slot must fit inside the reserved block
	if (SLOT_W < 1 || (2 << SLOT_W) > `DVIF_IMG_SIZE)
	begin : g_bad
		$error("dvif_island_nim slot range exceeds the input block");
	end

	logic ready_q;
	logic got_one_q;
	logic [15:0] one_q;
	logic [15:0] two_q;
	logic [15:0] num_q;
	logic upd_q;
	logic valid_q;
	logic take;

	assign take = link.valid && ready_q;

	// Nothing is taken until the global enable is set
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			ready_q <= 1'b0;
		else
			ready_q <= irq_enable_i;
	end

	// Adjacent pair placed from the slot position
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			num_q <= `DVIF_IMG_FIRST;
		else
			num_q <= `DVIF_IMG_FIRST + {slot_i, 1'b0};
	end

	// Sensor one is held until sensor two completes the pair
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			got_one_q <= 1'b0;
			one_q <= `DVIF_WORD_RST;
			two_q <= `DVIF_WORD_RST;
			upd_q <= 1'b0;
			valid_q <= 1'b0;
		end
		else
		begin
			upd_q <= 1'b0;
			if (take && link.chan == DVIF_CH_ONE)
			begin
				one_q <= link.word;
				got_one_q <= 1'b1;
			end
			else if (take && got_one_q)
			begin
				two_q <= link.word;
				got_one_q <= 1'b0;
				upd_q <= 1'b1;
				valid_q <= 1'b1;
			end
		end
	end

	// Published pair updates only as a whole
	logic [15:0] pub_one_q;
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			pub_one_q <= `DVIF_WORD_RST;
		else if (take && link.chan == DVIF_CH_TWO && got_one_q)
			pub_one_q <= one_q;
	end

	assign link.ready = ready_q;
	assign ch_one_word_o = pub_one_q;
	assign ch_two_word_o = two_q;
	assign first_reg_num_o = num_q;
	assign image_update_o = upd_q;
	assign image_valid_o = valid_q;
endmodule : dvif_island_nim
`default_nettype wire

/* test/dvif_link_properties.sv */
// Handshake and word format checker for the formatter link
`timescale 1ns/1ns
`default_nettype none
module dvif_link_properties
	import dvif_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic srst_i,
	// Link signals
	input wire logic valid,
	input wire logic ready,
	input wire dvif_word_t word,
	input wire dvif_chan_t chan
);
	dvif_chan_t last_chan_q;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	// Last channel taken; starts at two so a frame must open with one
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			last_chan_q <= DVIF_CH_TWO;
		else if (valid && ready)
			last_chan_q <= chan;
	end
	sequence take_one_s;
		valid && ready && chan == DVIF_CH_ONE;
	endsequence
	sequence offer_two_s;
		##[1:4] (valid && chan == DVIF_CH_TWO);
	endsequence
	pad_bits_a: assert property (valid |-> word[15] == 1'h0 && word[4:0] == 5'h00)
		else $error("pad bits set");
	mag_range_a: assert property (valid |-> word <= 16'h7FE0)
		else $error("word above top count");
	hold_valid_a: assert property (valid && !ready |=> valid)
		else $error("valid dropped untaken");
	hold_data_a: assert property (valid && !ready |=> $stable(word) && $stable(chan))
		else $error("word changed untaken");
	pair_close_a: assert property (take_one_s |-> offer_two_s)
		else $error("second word missing");
	two_after_one_a: assert property (valid && ready && chan == DVIF_CH_TWO |-> last_chan_q == DVIF_CH_ONE)
		else $error("sensor two word out of order");
	one_after_two_a: assert property (take_one_s |-> last_chan_q == DVIF_CH_TWO)
		else $error("sensor one word repeated");
	reset_idle_a: assert property ($fell(srst_i) |-> !valid && !ready)
		else $error("link busy after reset");
endmodule : dvif_link_properties
`default_nettype wire

/* test/testbench.sv */
// Bench joining the formatter and network interface ends
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic sys_clk_i = 1'h0;
	logic srst_i = 1'h1;
	logic conv_done_i = 1'h0;
	logic irq_enable_i = 1'h0;
	logic [9:0] conv_one_i = 10'h000;
	logic [9:0] conv_two_i = 10'h000;
	logic [7:0] slot_i = 8'h05;
	logic conv_start_o, refresh_o, overrun_o, image_update_o, image_valid_o;
	logic [15:0] ch_one_word_o, ch_two_word_o, first_reg_num_o;
	int errors = 0;
	int samples_checked = 0;
	int n;
	// Rows: sensor one, sensor two, expected word one, expected word two
	logic [51:0] rows [4] = '{
		{10'h000, 10'h3FF, 16'h0000, 16'h7FE0},
		{10'h3E8, 10'h001, 16'h7D00, 16'h0020},
		{10'h3E9, 10'h200, 16'h7D20, 16'h4000},
		{10'h155, 10'h2AA, 16'h2AA0, 16'h5540}};
	dvif_link_if dvif_link_if_i (.sys_clk_i(sys_clk_i));
	dvif_formatter #(.REFRESH_CYC(20), .FIFO_DEPTH(4)) dvif_formatter_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
		.conv_start_o(conv_start_o), .conv_done_i(conv_done_i), .conv_one_i(conv_one_i), .conv_two_i(conv_two_i),
		.refresh_o(refresh_o), .overrun_o(overrun_o), .link(dvif_link_if_i.dev));
	dvif_island_nim #(.SLOT_W(8)) dvif_island_nim_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
		.irq_enable_i(irq_enable_i), .slot_i(slot_i), .ch_one_word_o(ch_one_word_o),
		.ch_two_word_o(ch_two_word_o), .first_reg_num_o(first_reg_num_o), .image_update_o(image_update_o),
		.image_valid_o(image_valid_o), .link(dvif_link_if_i.nim));
	dvif_link_properties dvif_link_properties_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
		.valid(dvif_link_if_i.valid), .ready(dvif_link_if_i.ready), .word(dvif_link_if_i.word),
		.chan(dvif_link_if_i.chan));
	// 100 MHz clock
	initial
	begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	//----------------------------------------
	// Helpers
	//----------------------------------------
	task check(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : check
	task stop_test();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : stop_test
	// Bounded wait for a one-cycle pulse, looked at just after each edge
	task wait_hi(input int sel);
		logic hit;
		hit = 1'h0;
		for (int k = 0; k < 200 && hit !== 1'h1; k++)
		begin
			@(posedge sys_clk_i);
			#1;
			hit = (sel == 0) ? conv_start_o : (sel == 1) ? image_update_o : overrun_o;
		end
		check({15'h0000, hit}, 16'h0001);
		if (hit !== 1'h1)
		begin
			stop_test();
		end
	endtask : wait_hi
	// Answer the next conversion start with a result pair
	task convert(input logic [9:0] a, input logic [9:0] b);
		wait_hi(0);
		conv_one_i = a;
		conv_two_i = b;
		conv_done_i = 1'h1;
		@(posedge sys_clk_i);
		#1 conv_done_i = 1'h0;
	endtask : convert
	//----------------------------------------
	// Main sequence
	//----------------------------------------
	initial
	begin
		repeat (2) @(posedge sys_clk_i);
		#1 srst_i = 1'h0;
		irq_enable_i = 1'h1;
		for (int r = 0; r < 4; r++)
		begin
			convert(rows[r][51:42], rows[r][41:32]);
			wait_hi(1);
			check(ch_one_word_o, rows[r][31:16]);
			check(ch_two_word_o, rows[r][15:0]);
		end
		check(first_reg_num_o, 16'hB15A);
		check({15'h0000, image_valid_o}, 16'h0001);
		$display("test table done");
		// Start to start spacing while results come back at once
		wait_hi(0);
		conv_done_i = 1'h1;
		n = 0;
		do
		begin
			@(posedge sys_clk_i);
			#1 conv_done_i = 1'h0;
			n++;
		end while (conv_start_o !== 1'h1 && n < 100);
		check(n[15:0], 16'h0014);
		$display("test refresh done");
		// Enable off: link stalls, unanswered ticks overrun, pair waits
		irq_enable_i = 1'h0;
		wait_hi(2);
		conv_one_i = 10'h0AA;
		conv_two_i = 10'h3FF;
		conv_done_i = 1'h1;
		@(posedge sys_clk_i);
		#1 conv_done_i = 1'h0;
		// Frame is queued two edges after the capture, though the far side refuses it
		repeat (2) @(posedge sys_clk_i);
		#1;
		check({15'h0000, refresh_o}, 16'h0001);
		repeat (27) @(posedge sys_clk_i);
		#1;
		check(ch_one_word_o, 16'h2AA0);
		irq_enable_i = 1'h1;
		wait_hi(1);
		check(ch_one_word_o, 16'h1540);
		check(ch_two_word_o, 16'h7FE0);
		$display("test stall done");
		// Reset in mid-run clears the image
		srst_i = 1'h1;
		repeat (2) @(posedge sys_clk_i);
		#1;
		check(ch_one_word_o, 16'h0000);
		check(first_reg_num_o, 16'hB150);
		check({15'h0000, image_valid_o}, 16'h0000);
		srst_i = 1'h0;
		repeat (3) @(posedge sys_clk_i);
		$display("test reset done");
		stop_test();
	end
endmodule : testbench
`default_nettype wire
